// ==== src/pirtc_top.sv ====
// periodic interval generator with register port and interrupt
//
// The strobed register port is this design's own decision.
`timescale 1ns/100ps
`include "pirtc_cfg.svh"

////////////////////////////////////////////////////////////////////////////////

// What this block does
// - counting happens only while the low-frequency oscillator runs and never in deep sleep.
// - with the clock-gate bit at 0 control writes are ignored and the counter cannot step; at 1 it may operate.
// - the run bit enables counting, and it reads 0 right after reset.
// - select codes 0 to 5 give 2^15 down to 2^10 periods, 6 gives 2^9, 7 gives 2^8.
// - while running, writes to the select field are ignored.
// - a write that starts the block may load select; a write that stops it keeps select.
// - oscillator off, stop or deep sleep while running clears run and keeps select.
// - while running with the gate bit at 1 the counter steps once per low-frequency clock period.
// - reaching the interval raises the interrupt and the counter keeps going.
// - clearing run zeroes the counter and stops it.
module pirtc_top (
	// clock and reset
	input wire logic clk,
	input wire logic rst,

	// register port
	input wire pirtc_pkg::pirtc_bus_req_t bus_req,
	output logic [`PIRTC_DATA_W-1:0] rdata,

	// low-frequency clock pin
	input wire logic lowfreq_clock,

	// system mode
	input wire logic lowfreq_osc_enable,
	input wire logic stop_mode,
	input wire logic deep_sleep_mode,

	// events
	output logic interval_irq,
	output logic irq
);

////////////////////////////////////////////////////////////////////////////////
// declarations

	logic [`PIRTC_DATA_W-1:0] gate_q;
	pirtc_pkg::pirtc_ctrl_t ctrl_q;
	logic [`PIRTC_DATA_W-1:0] stat_q;
	logic [`PIRTC_DATA_W-1:0] mask_q;
	logic [`PIRTC_DATA_W-1:0] rdata_q;

	logic lf_meta_q;
	logic lf_sync_q;
	logic lf_prev_q;
	logic lf_edge;

	logic gate_on;
	logic clock_ok;
	logic hw_stop;
	logic cnt_tick;
	logic cnt_clr;
	logic [`PIRTC_CNT_W-1:0] cnt;
	logic carry;

	logic wr_gate;
	logic wr_ctrl;
	logic wr_stat;
	logic wr_mask;
	logic rd_stat;

	logic [`PIRTC_SEL_W-1:0] wsel;
	logic wrun;

////////////////////////////////////////////////////////////////////////////////
// address decode

	always_comb begin
		wr_gate = 1'b0;
		wr_ctrl = 1'b0;
		wr_stat = 1'b0;
		wr_mask = 1'b0;
		if (!bus_req.wr) begin
			wr_gate = 1'b0;
		end else if (bus_req.addr == `PIRTC_ADDR_GATE) begin
			wr_gate = 1'b1;
		end else if (bus_req.addr == `PIRTC_ADDR_CTRL) begin
			wr_ctrl = 1'b1;
		end else if (bus_req.addr == `PIRTC_ADDR_STAT) begin
			wr_stat = 1'b1;
		end else if (bus_req.addr == `PIRTC_ADDR_MASK) begin
			wr_mask = 1'b1;
		end
	end

	assign rd_stat = bus_req.rd && (bus_req.addr == `PIRTC_ADDR_STAT);

	assign wsel = bus_req.wdata[`PIRTC_SEL_MSB:`PIRTC_SEL_LSB];
	assign wrun = bus_req.wdata[`PIRTC_RUN_BIT];

////////////////////////////////////////////////////////////////////////////////
// low-frequency clock synchroniser and edge detect

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lf_meta_q <= 1'b0;
			lf_sync_q <= 1'b0;
			lf_prev_q <= 1'b0;
		end else begin
			lf_meta_q <= lowfreq_clock;
			lf_sync_q <= lf_meta_q;
			lf_prev_q <= lf_sync_q;
		end
	end

	// one count per rising edge of the low-frequency clock
	assign lf_edge = lf_sync_q && !lf_prev_q;

////////////////////////////////////////////////////////////////////////////////
// power gate register

	// whole byte is read/write; only the gate bit steers this block
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gate_q <= `PIRTC_RST_GATE;
		end else if (wr_gate) begin
			gate_q <= bus_req.wdata;
		end
	end

	assign gate_on = gate_q[`PIRTC_GATE_BIT];

////////////////////////////////////////////////////////////////////////////////
// control register

	assign clock_ok = lowfreq_osc_enable && !stop_mode && !deep_sleep_mode;
	assign hw_stop = ctrl_q.run && !clock_ok;

	// select loads only while stopped, including the write that starts the block
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= '0;
		end else begin
			if (wr_ctrl && gate_on && !ctrl_q.run) begin
				ctrl_q.sel <= wsel;
			end
			if (hw_stop) begin
				ctrl_q.run <= 1'b0;
			end else if (wr_ctrl && gate_on) begin
				ctrl_q.run <= wrun;
			end
		end
	end

////////////////////////////////////////////////////////////////////////////////
// binary counter

	assign cnt_tick = ctrl_q.run && gate_on && clock_ok && lf_edge;
	assign cnt_clr = !ctrl_q.run;

	pirtc_counter u_counter (
		.clk(clk),
		.rst(rst),
		.tick(cnt_tick),
		.clr(cnt_clr),
		.sel(ctrl_q.sel),
		.cnt_q(cnt),
		.carry_q(carry)
	);

	assign interval_irq = carry;

////////////////////////////////////////////////////////////////////////////////
// interrupt status and mask

	// a new event beats the clearing read in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stat_q <= `PIRTC_RST_STAT;
		end else if (carry) begin
			stat_q[`PIRTC_EVT_BIT] <= 1'b1;
		end else if (rd_stat) begin
			stat_q <= `PIRTC_ZERO;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mask_q <= `PIRTC_RST_MASK;
		end else if (wr_mask) begin
			mask_q[`PIRTC_EVT_BIT] <= bus_req.wdata[`PIRTC_EVT_BIT];
		end
	end

	assign irq = |(stat_q & mask_q);

////////////////////////////////////////////////////////////////////////////////
// read data, one cycle after the strobe

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_q <= `PIRTC_ZERO;
		end else if (!bus_req.rd) begin
			rdata_q <= `PIRTC_ZERO;
		end else if (bus_req.addr == `PIRTC_ADDR_GATE) begin
			rdata_q <= gate_q;
		end else if (bus_req.addr == `PIRTC_ADDR_CTRL) begin
			rdata_q <= {4'h0, ctrl_q.sel, ctrl_q.run};
		end else if (bus_req.addr == `PIRTC_ADDR_STAT) begin
			rdata_q <= stat_q;
		end else if (bus_req.addr == `PIRTC_ADDR_MASK) begin
			rdata_q <= mask_q;
		end else begin
			rdata_q <= `PIRTC_ZERO;
		end
	end

	assign rdata = rdata_q;

////////////////////////////////////////////////////////////////////////////////
// assertions

	default clocking cb @(posedge clk);
	endclocking

	default disable iff (rst);

	sequence s_ctrl_write;
		wr_ctrl && gate_on;
	endsequence

	sequence s_tick_at_tap;
		cnt_tick &&
			((cnt & pirtc_pkg::pirtc_sel_mask(ctrl_q.sel)) ==
			pirtc_pkg::pirtc_sel_mask(ctrl_q.sel));
	endsequence

	sequence s_leave_run;
		ctrl_q.run ##1 !ctrl_q.run;
	endsequence

	AST_RUN_CAUSE: assert property (
		$rose(ctrl_q.run) |-> $past(wr_ctrl && gate_on && wrun))
		else $error("run set without a control write");

	AST_SEL_LOCKED: assert property (
		ctrl_q.run && wr_ctrl |=> $stable(ctrl_q.sel))
		else $error("select changed while running");

	AST_SEL_LOAD: assert property (
		s_ctrl_write and !ctrl_q.run |=> ctrl_q.sel == $past(wsel))
		else $error("select not loaded while stopped");

	AST_HW_STOP: assert property (
		hw_stop |=> !ctrl_q.run && $stable(ctrl_q.sel))
		else $error("run not cleared on clock loss");

	AST_SLEEP_IDLE: assert property (
		deep_sleep_mode [*3] |-> cnt == '0 && !carry)
		else $error("counter active in deep sleep");

	AST_GATE_OFF: assert property (
		wr_ctrl && !gate_on && !ctrl_q.run |=> !ctrl_q.run && $stable(ctrl_q.sel))
		else $error("control written with gate off");

	AST_CNT_STEP: assert property (
		cnt_tick |=> cnt == $past(cnt) + `PIRTC_CNT_W'(1))
		else $error("counter did not step");

	AST_CNT_CLEAR: assert property (
		s_leave_run |=> cnt == '0 ##1 cnt == '0)
		else $error("counter not cleared after stop");

	AST_IRQ_CAUSE: assert property (
		s_tick_at_tap |=> interval_irq ##1 !interval_irq)
		else $error("interval pulse missing or too long");

	AST_IRQ_ONLY_TAP: assert property (
		interval_irq |-> $past(cnt_tick) && $past(ctrl_q.run))
		else $error("interval pulse without a tick");

	AST_KEEPS_COUNTING: assert property (
		interval_irq && ctrl_q.run |-> cnt == $past(cnt) + `PIRTC_CNT_W'(1))
		else $error("counter halted at interval");

	AST_UPPER_ZERO: assert property (
		bus_req.rd && bus_req.addr == `PIRTC_ADDR_CTRL |=> rdata[7:4] == 4'h0)
		else $error("upper control bits not zero");

	AST_STAT_STICKY: assert property (
		interval_irq |=> stat_q[`PIRTC_EVT_BIT] ##0 (irq == mask_q[`PIRTC_EVT_BIT]))
		else $error("status bit not set by event");

	AST_SEL_HOLD: assert property (
		!(wr_ctrl && gate_on && !ctrl_q.run) |=> $stable(ctrl_q.sel))
		else $error("select changed without a stopped write");

	AST_RUN_SET: assert property (
		wr_ctrl && gate_on && wrun && !hw_stop |=> ctrl_q.run)
		else $error("run not set by control write");

	AST_RUN_CLEAR_WR: assert property (
		wr_ctrl && gate_on && !wrun |=> !ctrl_q.run)
		else $error("run not cleared by control write");

	AST_STOP_KEEPS_SEL: assert property (
		ctrl_q.run && wr_ctrl && gate_on && !wrun |=> !ctrl_q.run && $stable(ctrl_q.sel))
		else $error("stopping write changed select");

	AST_CNT_IDLE_ZERO: assert property (
		!ctrl_q.run |=> cnt == '0)
		else $error("counter not held at zero while stopped");

	AST_GATE_NO_IRQ: assert property (
		!gate_on |=> !interval_irq)
		else $error("interval pulse with clock gate off");

	AST_CLOCK_LOSS_NO_IRQ: assert property (
		!clock_ok |=> !interval_irq)
		else $error("interval pulse without low-frequency clock");

	AST_TAP_ALIGNED: assert property (
		interval_irq |-> (cnt & pirtc_pkg::pirtc_sel_mask(ctrl_q.sel)) == '0)
		else $error("interval pulse off the selected tap");

	AST_CTRL_READ: assert property (
		bus_req.rd && bus_req.addr == `PIRTC_ADDR_CTRL |=>
		rdata == {4'h0, $past(ctrl_q.sel), $past(ctrl_q.run)})
		else $error("control read value wrong");

	AST_PULSE_ONE: assert property (
		interval_irq |=> !interval_irq)
		else $error("interval pulse longer than one cycle");

	AST_WRAP: assert property (
		cnt_tick && cnt == '1 |=> cnt == '0 && interval_irq)
		else $error("counter wrap without pulse");

	AST_HW_STOP_WINS: assert property (
		hw_stop && wr_ctrl |=> !ctrl_q.run)
		else $error("software set beat hardware stop");

	AST_STAT_WR_IGNORED: assert property (
		wr_stat && !carry |=> $stable(stat_q))
		else $error("status changed by a write");

endmodule

// ==== common/pirtc_cfg.svh ====
// constants for the periodic interval generator
`ifndef PIRTC_CFG_SVH
`define PIRTC_CFG_SVH

// register addresses on the plain register port
`define PIRTC_ADDR_W 16
`define PIRTC_ADDR_GATE 16'h0f76
`define PIRTC_ADDR_CTRL 16'h0fc8
`define PIRTC_ADDR_STAT 16'h0fc9
`define PIRTC_ADDR_MASK 16'h0fca

// data width and reset values
`define PIRTC_DATA_W 8
`define PIRTC_RST_GATE 8'h00
`define PIRTC_RST_CTRL 8'h00
`define PIRTC_RST_STAT 8'h00
`define PIRTC_RST_MASK 8'h00
`define PIRTC_ZERO 8'h00

// field positions
`define PIRTC_GATE_BIT 5
`define PIRTC_RUN_BIT 0
`define PIRTC_SEL_LSB 1
`define PIRTC_SEL_MSB 3
`define PIRTC_SEL_W 3
`define PIRTC_EVT_BIT 0

// binary counter and interval exponents
`define PIRTC_CNT_W 15
`define PIRTC_EXP_MAX 15
`define PIRTC_EXP_LAST_BIN 5
`define PIRTC_CODE_512 3'h6
`define PIRTC_EXP_512 9
`define PIRTC_EXP_256 8

`endif

// ==== common/pirtc_pkg.sv ====
// types and shared decoding for the periodic interval generator
`include "pirtc_cfg.svh"

package pirtc_pkg;

	typedef struct packed {
		logic [`PIRTC_ADDR_W-1:0] addr;
		logic [`PIRTC_DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} pirtc_bus_req_t;

	typedef struct packed {
		logic [`PIRTC_SEL_W-1:0] sel;
		logic run;
	} pirtc_ctrl_t;

	// low bits of the counter that must all be ones before the selected carry
	function automatic logic [`PIRTC_CNT_W-1:0] pirtc_sel_mask(
		input logic [`PIRTC_SEL_W-1:0] sel);
		logic [31:0] ex;
		logic [31:0] full;
		ex = 32'h0000_0000;
		full = 32'h0000_0000;
		if (sel <= `PIRTC_SEL_W'(`PIRTC_EXP_LAST_BIN)) begin
			ex = `PIRTC_EXP_MAX - {29'h0000_0000, sel};
		end else if (sel == `PIRTC_CODE_512) begin
			ex = `PIRTC_EXP_512;
		end else begin
			ex = `PIRTC_EXP_256;
		end
		full = (32'h0000_0001 << ex) - 32'h0000_0001;
		return full[`PIRTC_CNT_W-1:0];
	endfunction

endpackage

// ==== src/pirtc_counter.sv ====
// binary counter with selectable carry tap
`timescale 1ns/100ps
`include "pirtc_cfg.svh"

module pirtc_counter (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic tick,
	input wire logic clr,
	input wire logic [`PIRTC_SEL_W-1:0] sel,
	// status
	output logic [`PIRTC_CNT_W-1:0] cnt_q,
	output logic carry_q
);

	logic [`PIRTC_CNT_W-1:0] mask;
	logic carry_d;

	assign mask = pirtc_pkg::pirtc_sel_mask(sel);
	// carry into the bit just above the selected interval
	assign carry_d = tick && ((cnt_q & mask) == mask);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (clr) begin
			cnt_q <= '0;
		end else if (tick) begin
			cnt_q <= cnt_q + `PIRTC_CNT_W'(1);
		end
	end

	// counter wraps on its own; the pulse does not stop it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			carry_q <= 1'b0;
		end else begin
			carry_q <= carry_d;
		end
	end

endmodule

// ==== bench/pirtc_tb.sv ====
// self-checking bench for the periodic interval generator
`timescale 1ns/100ps
`include "pirtc_cfg.svh"

`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, e); end end

module testbench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	pirtc_pkg::pirtc_bus_req_t req = '0;
	logic [7:0] rdata;
	logic lfc = 1'b0;
	logic osc_en = 1'b1;
	logic stop_m = 1'b0;
	logic sleep_m = 1'b0;
	logic interval_irq;
	logic irq;
	int err_count = 0;
	int checks = 0;
	int pulses = 0;

	always #2 clk = ~clk;

	pirtc_top dut (.clk(clk), .rst(rst), .bus_req(req), .rdata(rdata), .lowfreq_clock(lfc),
		.lowfreq_osc_enable(osc_en), .stop_mode(stop_m), .deep_sleep_mode(sleep_m),
		.interval_irq(interval_irq), .irq(irq));

	always @(posedge clk) begin
		if (interval_irq === 1'b1) begin
			pulses++;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clk);
		req.wr <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clk);
		req.rd <= 1'b0;
		#1;
		`CHK(rdata, e)
	endtask

	// low-frequency pulses, two clocks high and two low, then sync settle
	task automatic lf(input int n);
		repeat (n) begin
			@(posedge clk);
			lfc <= 1'b1;
			repeat (2) @(posedge clk);
			lfc <= 1'b0;
			@(posedge clk);
		end
		repeat (8) @(posedge clk);
	endtask

	task automatic interval(input logic [2:0] code, input int n);
		int p0;
		wr(`PIRTC_ADDR_CTRL, {4'h0, code, 1'b1});
		p0 = pulses;
		lf(n - 1);
		`CHK(pulses - p0, 0)
		lf(1);
		`CHK(pulses - p0, 1)
		lf(n);
		`CHK(pulses - p0, 2)
		wr(`PIRTC_ADDR_CTRL, {4'h0, code, 1'b0});
		$display("test interval code %0d done", code);
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd(`PIRTC_ADDR_GATE, 8'h00);
		rd(`PIRTC_ADDR_CTRL, 8'h00);
		rd(`PIRTC_ADDR_STAT, 8'h00);
		rd(`PIRTC_ADDR_MASK, 8'h00);
		wr(`PIRTC_ADDR_CTRL, 8'h0f);
		rd(`PIRTC_ADDR_CTRL, 8'h00);
		wr(`PIRTC_ADDR_GATE, 8'h20);
		rd(`PIRTC_ADDR_GATE, 8'h20);
		wr(16'h0f77, 8'h5a);
		rd(16'h0f77, 8'h00);
		$display("test reset and gate done");
		wr(`PIRTC_ADDR_CTRL, 8'hf7);
		rd(`PIRTC_ADDR_CTRL, 8'h07);
		wr(`PIRTC_ADDR_CTRL, 8'h0b);
		rd(`PIRTC_ADDR_CTRL, 8'h07);
		wr(`PIRTC_ADDR_CTRL, 8'h0c);
		rd(`PIRTC_ADDR_CTRL, 8'h06);
		for (int c = 0; c < 8; c++) begin
			wr(`PIRTC_ADDR_CTRL, {4'h0, 3'(c), 1'b0});
			rd(`PIRTC_ADDR_CTRL, {4'h0, 3'(c), 1'b0});
		end
		$display("test control fields done");
		// each hardware stop condition in turn, then a start attempt during it
		for (int i = 0; i < 3; i++) begin
			wr(`PIRTC_ADDR_CTRL, 8'h05);
			osc_en <= (i != 0);
			stop_m <= (i == 1);
			sleep_m <= (i == 2);
			repeat (3) @(posedge clk);
			wr(`PIRTC_ADDR_CTRL, 8'h05);
			rd(`PIRTC_ADDR_CTRL, 8'h04);
			osc_en <= 1'b1;
			stop_m <= 1'b0;
			sleep_m <= 1'b0;
		end
		sleep_m <= 1'b1;
		wr(`PIRTC_ADDR_CTRL, 8'h0f);
		lf(300);
		`CHK(pulses, 0)
		sleep_m <= 1'b0;
		$display("test mode stops done");
		for (int c = 4; c < 8; c++) begin
			interval(3'(c), (c == 7) ? 256 : (c == 6) ? 512 : (1 << (15 - c)));
		end
		wr(`PIRTC_ADDR_CTRL, 8'h0f);
		lf(100);
		wr(`PIRTC_ADDR_CTRL, 8'h0e);
		interval(3'h7, 256);
		// gate dropped only while stopped; control writes must then be ignored
		wr(`PIRTC_ADDR_GATE, 8'h00);
		wr(`PIRTC_ADDR_CTRL, 8'h03);
		rd(`PIRTC_ADDR_CTRL, 8'h0e);
		wr(`PIRTC_ADDR_GATE, 8'h20);
		#1;
		`CHK(irq, 1'b0)
		wr(`PIRTC_ADDR_MASK, 8'h01);
		@(posedge clk);
		#1;
		`CHK(irq, 1'b1)
		rd(`PIRTC_ADDR_MASK, 8'h01);
		wr(`PIRTC_ADDR_STAT, 8'h00);
		rd(`PIRTC_ADDR_STAT, 8'h01);
		rd(`PIRTC_ADDR_STAT, 8'h00);
		`CHK(irq, 1'b0)
		$display("test interrupt done");
		stop_test();
	end

	initial begin
		repeat (90000) @(posedge clk);
		err_count++;
		$display("[FAIL] %0t got %h exp %h", $time, 1'b0, 1'b1);
		stop_test();
	end
endmodule
